// [core/spc_pkg.sv]
package spc_pkg;
   localparam int unsigned SPC_AW = 32;
   localparam int unsigned SPC_DW = 32;
   localparam int unsigned SPC_SELW = 16;
   localparam int unsigned SPC_ACCW = 8;
   localparam int unsigned SPC_PLW = 2;

   // register byte offsets
   localparam logic [7:0] SPC_OFS_CMD = 8'h00;
   localparam logic [7:0] SPC_OFS_SEL = 8'h04;
   localparam logic [7:0] SPC_OFS_ACC = 8'h08;
   localparam logic [7:0] SPC_OFS_OPND = 8'h0C;
   localparam logic [7:0] SPC_OFS_STAT = 8'h10;
   localparam logic [7:0] SPC_OFS_RESULT = 8'h14;
   localparam logic [7:0] SPC_OFS_CS = 8'h18;
   localparam logic [7:0] SPC_OFS_SS = 8'h1C;
   localparam logic [7:0] SPC_OFS_DATA = 8'h20;
   localparam logic [7:0] SPC_OFS_EXTRA = 8'h24;
   localparam logic [7:0] SPC_OFS_LAST = 8'h24;

   // command word fields
   localparam int unsigned SPC_CMD_OP_LSB = 0;
   localparam int unsigned SPC_CMD_SEG_LSB = 2;
   localparam int unsigned SPC_CMD_XFER_LSB = 4;
   localparam int unsigned SPC_CMD_GATE_BIT = 6;
   localparam int unsigned SPC_CMD_GDPL_LSB = 7;

   // access byte fields
   localparam int unsigned SPC_ACC_LVL_LSB = 5;
   localparam int unsigned SPC_ACC_EXEC_BIT = 3;
   localparam int unsigned SPC_ACC_CONF_BIT = 2;
   localparam int unsigned SPC_ACC_RW_BIT = 1;

   // selector and status fields
   localparam int unsigned SPC_SEL_RPL_LSB = 0;
   localparam int unsigned SPC_STAT_FAULT_BIT = 0;
   localparam int unsigned SPC_STAT_GRANT_BIT = 1;
   localparam int unsigned SPC_STAT_LVL_LSB = 2;

   // reset values
   localparam logic [15:0] SPC_SEL_RST = 16'h0000;
   localparam logic [7:0] SPC_ACC_RST = 8'h00;
   localparam logic [9:0] SPC_CMD_RST = 10'h000;
   localparam logic [1:0] SPC_PL_MOST = 2'h0;

   typedef enum logic [1:0] {SPC_OP_NONE, SPC_OP_LOAD, SPC_OP_STAMP,
      SPC_OP_XFER} spc_op_t;
   typedef enum logic [1:0] {SPC_SEG_CS, SPC_SEG_SS, SPC_SEG_DATA,
      SPC_SEG_EXTRA} spc_seg_t;
   typedef enum logic [1:0] {SPC_XF_SHORT, SPC_XF_JUMP, SPC_XF_CALL,
      SPC_XF_RET} spc_xfer_t;
endpackage

// [core/spc_priv_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_priv_cmp (
   input wire logic [1:0] cur_priv_level,
   input wire logic [1:0] requested_priv_level,
   input wire logic [1:0] descriptor_priv_level,
   output logic [1:0] effective_priv_level,
   output logic access_ok,
   output logic stack_ok,
   output logic same_level,
   output logic more_priv
);
   // plain unsigned two-bit compares; 0 is the most privileged
   always_comb begin
      effective_priv_level = (requested_priv_level > cur_priv_level) ?
         requested_priv_level : cur_priv_level;
      access_ok = (effective_priv_level <= descriptor_priv_level);
      stack_ok = (descriptor_priv_level == cur_priv_level) &&
         (requested_priv_level == cur_priv_level);
      same_level = (descriptor_priv_level == cur_priv_level);
      more_priv = (descriptor_priv_level < cur_priv_level);
   end
endmodule
`default_nettype wire

// [core/spc_stamp.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_stamp (
   input wire logic [15:0] selector_in,
   input wire logic [15:0] operand,
   output logic [15:0] selector_out
);
   logic [1:0] req_in;
   logic [1:0] opnd_pl;
   always_comb begin
      req_in = selector_in[1:0];
      opnd_pl = operand[1:0];
      // only ever weakens the selector, never strengthens it
      selector_out = {selector_in[15:2],
         (opnd_pl > req_in) ? opnd_pl : req_in};
   end
endmodule
`default_nettype wire

// [core/spc_checker.sv]
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module spc_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [spc_pkg::SPC_AW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [spc_pkg::SPC_DW-1:0] hwdata,
   input wire logic hready,
   output logic [spc_pkg::SPC_DW-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic gp_fault,
   output logic [15:0] fault_selector,
   output logic [1:0] current_priv_level
);
   import spc_pkg::*;

   function automatic logic mapped(input logic [SPC_AW-1:0] a);
      mapped = (a[SPC_AW-1:8] == '0) && (a[1:0] == 2'h0) &&
         (a[7:0] <= SPC_OFS_LAST);
   endfunction

   // bus state
   logic wr_pend_r, wr_pend_nxt;
   logic rd_pend_r, rd_pend_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [SPC_DW-1:0] hrdata_r, hrdata_nxt;
   logic hreadyout_r, hreadyout_nxt;

   // software-visible state
   logic [9:0] cmd_r, cmd_nxt;
   logic go_r, go_nxt;
   logic [15:0] sel_r, sel_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic [15:0] opnd_r, opnd_nxt;
   logic [15:0] result_r, result_nxt;
   logic fault_r, fault_nxt;
   logic grant_r, grant_nxt;
   logic [15:0] seg_sel_r [4];
   logic [15:0] seg_sel_nxt [4];
   logic [7:0] seg_acc_r [4];
   logic [7:0] seg_acc_nxt [4];

   // outward signals to the execution unit
   logic gp_fault_r, gp_fault_nxt;
   logic [15:0] fault_sel_r, fault_sel_nxt;

   // decode of the pending command
   spc_op_t op;
   spc_seg_t seg;
   spc_xfer_t xf;
   logic gate;
   logic [1:0] gate_lvl;
   logic [1:0] cur_lvl, req_lvl, desc_lvl;
   logic is_code, conf, rw;
   logic [1:0] eff_lvl;
   logic acc_ok, stk_ok, same_lvl, more_priv;
   logic gate_ok;
   logic [15:0] stamped;
   logic wr_stat;

   always_comb begin
      op = spc_op_t'(cmd_r[SPC_CMD_OP_LSB +: 2]);
      seg = spc_seg_t'(cmd_r[SPC_CMD_SEG_LSB +: 2]);
      xf = spc_xfer_t'(cmd_r[SPC_CMD_XFER_LSB +: 2]);
      gate = cmd_r[SPC_CMD_GATE_BIT];
      gate_lvl = cmd_r[SPC_CMD_GDPL_LSB +: 2];
      cur_lvl = seg_sel_r[SPC_SEG_CS][SPC_SEL_RPL_LSB +: 2];
      req_lvl = sel_r[SPC_SEL_RPL_LSB +: 2];
      desc_lvl = acc_r[SPC_ACC_LVL_LSB +: 2];
      is_code = acc_r[SPC_ACC_EXEC_BIT];
      conf = acc_r[SPC_ACC_CONF_BIT];
      rw = acc_r[SPC_ACC_RW_BIT];
   end

   spc_priv_cmp u_seg_cmp (
      .cur_priv_level(cur_lvl),
      .requested_priv_level(req_lvl),
      .descriptor_priv_level(desc_lvl),
      .effective_priv_level(eff_lvl),
      .access_ok(acc_ok),
      .stack_ok(stk_ok),
      .same_level(same_lvl),
      .more_priv(more_priv)
   );

   // the gate is checked with the same data-style rule
   spc_priv_cmp u_gate_cmp (
      .cur_priv_level(cur_lvl),
      .requested_priv_level(req_lvl),
      .descriptor_priv_level(gate_lvl),
      .effective_priv_level(),
      .access_ok(gate_ok),
      .stack_ok(),
      .same_level(),
      .more_priv()
   );

   spc_stamp u_stamp (
      .selector_in(sel_r),
      .operand(opnd_r),
      .selector_out(stamped)
   );

   // bus front end: writes take no wait state, reads take one so that a
   // read right behind a register write sees the new value; one right behind a command does not yet see its result
   always_comb begin
      wr_pend_nxt = 1'b0;
      rd_pend_nxt = 1'b0;
      addr_nxt = addr_r;
      hreadyout_nxt = 1'b1;
      hrdata_nxt = hrdata_r;
      if (hready && hsel && htrans[1]) begin
         addr_nxt = mapped(haddr) ? haddr[7:0] : 8'hFF;
         wr_pend_nxt = hwrite;
         rd_pend_nxt = !hwrite;
         hreadyout_nxt = hwrite;
      end
      if (rd_pend_r) begin
         unique case (addr_r)
            SPC_OFS_CMD: hrdata_nxt = {22'h000000, cmd_r};
            SPC_OFS_SEL: hrdata_nxt = {16'h0000, sel_r};
            SPC_OFS_ACC: hrdata_nxt = {24'h000000, acc_r};
            SPC_OFS_OPND: hrdata_nxt = {16'h0000, opnd_r};
            SPC_OFS_STAT: hrdata_nxt = {28'h0000000, cur_lvl, grant_r, fault_r};
            SPC_OFS_RESULT: hrdata_nxt = {16'h0000, result_r};
            SPC_OFS_CS: hrdata_nxt = {16'h0000, seg_sel_r[SPC_SEG_CS]};
            SPC_OFS_SS: hrdata_nxt = {16'h0000, seg_sel_r[SPC_SEG_SS]};
            SPC_OFS_DATA: hrdata_nxt = {16'h0000, seg_sel_r[SPC_SEG_DATA]};
            SPC_OFS_EXTRA: hrdata_nxt = {16'h0000, seg_sel_r[SPC_SEG_EXTRA]};
            default: hrdata_nxt = 32'h00000000;
         endcase
         hreadyout_nxt = 1'b1;
      end
   end

   // register writes and command execution
   always_comb begin
      cmd_nxt = cmd_r;
      go_nxt = 1'b0;
      sel_nxt = sel_r;
      acc_nxt = acc_r;
      opnd_nxt = opnd_r;
      result_nxt = result_r;
      fault_nxt = fault_r;
      grant_nxt = grant_r;
      seg_sel_nxt = seg_sel_r;
      seg_acc_nxt = seg_acc_r;
      gp_fault_nxt = 1'b0;
      fault_sel_nxt = fault_sel_r;
      wr_stat = 1'b0;
      if (wr_pend_r) begin
         unique case (addr_r)
            SPC_OFS_CMD: begin
               cmd_nxt = hwdata[9:0];
               go_nxt = 1'b1;
            end
            SPC_OFS_SEL: sel_nxt = hwdata[15:0];
            SPC_OFS_ACC: acc_nxt = hwdata[7:0];
            SPC_OFS_OPND: opnd_nxt = hwdata[15:0];
            SPC_OFS_STAT: wr_stat = hwdata[SPC_STAT_FAULT_BIT];
            SPC_OFS_CS: seg_sel_nxt[SPC_SEG_CS] = hwdata[15:0];
            default: wr_stat = 1'b0;
         endcase
      end
      // write-one clears the sticky fault; a new fault below wins
      if (wr_stat) begin
         fault_nxt = 1'b0;
      end
      if (go_r) begin
         grant_nxt = 1'b1;
         unique case (op)
            SPC_OP_LOAD: begin
               // checked here at load time, not at a later access
               unique case (seg)
                  SPC_SEG_SS: grant_nxt = !is_code && rw && stk_ok;
                  SPC_SEG_DATA, SPC_SEG_EXTRA: begin
                     // execute-only code never goes into a data register
                     grant_nxt = (!is_code || rw) &&
                        ((is_code && conf) || acc_ok);
                  end
                  SPC_SEG_CS: grant_nxt = 1'b0;
               endcase
               // a refused load leaves target and descriptor untouched
               if (grant_nxt) begin
                  seg_sel_nxt[seg] = sel_r;
                  seg_acc_nxt[seg] = acc_r;
               end
            end
            SPC_OP_STAMP: result_nxt = stamped;
            SPC_OP_XFER: begin
               unique case (xf)
                  SPC_XF_SHORT: grant_nxt = 1'b1;
                  SPC_XF_JUMP: begin
                     grant_nxt = same_lvl && (!gate || gate_ok);
                  end
                  SPC_XF_CALL: begin
                     if (same_lvl) begin
                        grant_nxt = !gate || gate_ok;
                     end else begin
                        grant_nxt = gate && gate_ok && more_priv;
                     end
                  end
                  SPC_XF_RET: grant_nxt = !gate && (desc_lvl >= cur_lvl);
               endcase
               // through a gate the new code segment is entered as usual
               if (grant_nxt && xf != SPC_XF_SHORT) begin
                  seg_sel_nxt[SPC_SEG_CS] = {sel_r[15:2], desc_lvl};
                  seg_acc_nxt[SPC_SEG_CS] = acc_r;
               end
            end
            SPC_OP_NONE: grant_nxt = 1'b1;
         endcase
         if (!grant_nxt) begin
            fault_nxt = 1'b1;
            gp_fault_nxt = 1'b1;
            fault_sel_nxt = {sel_r[15:2], 2'h0};
            result_nxt = {sel_r[15:2], 2'h0};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b1;
         cmd_r <= SPC_CMD_RST;
         go_r <= 1'b0;
         sel_r <= SPC_SEL_RST;
         acc_r <= SPC_ACC_RST;
         opnd_r <= SPC_SEL_RST;
         result_r <= SPC_SEL_RST;
         fault_r <= 1'b0;
         grant_r <= 1'b0;
         gp_fault_r <= 1'b0;
         fault_sel_r <= SPC_SEL_RST;
         for (int i = 0; i < 4; i++) begin
            seg_sel_r[i] <= SPC_SEL_RST;
            seg_acc_r[i] <= SPC_ACC_RST;
         end
      end else begin
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         addr_r <= addr_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_r <= hreadyout_nxt;
         cmd_r <= cmd_nxt;
         go_r <= go_nxt;
         sel_r <= sel_nxt;
         acc_r <= acc_nxt;
         opnd_r <= opnd_nxt;
         result_r <= result_nxt;
         fault_r <= fault_nxt;
         grant_r <= grant_nxt;
         gp_fault_r <= gp_fault_nxt;
         fault_sel_r <= fault_sel_nxt;
         for (int i = 0; i < 4; i++) begin
            seg_sel_r[i] <= seg_sel_nxt[i];
            seg_acc_r[i] <= seg_acc_nxt[i];
         end
      end
   end

   logic [1:0] cur_lvl_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_lvl_r <= SPC_PL_MOST;
      end else begin
         cur_lvl_r <= seg_sel_nxt[SPC_SEG_CS][1:0];
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign gp_fault = gp_fault_r;
   assign fault_selector = fault_sel_r;
   assign current_priv_level = cur_lvl_r;
endmodule
`default_nettype wire

// [verification/spc_prot_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_prot_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [spc_pkg::SPC_AW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [spc_pkg::SPC_DW-1:0] hwdata,
   input wire logic hready,
   input wire logic [spc_pkg::SPC_DW-1:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic gp_fault,
   input wire logic [15:0] fault_selector,
   input wire logic [1:0] current_priv_level
);
   import spc_pkg::*;
   logic ph_w;
   logic cmd;
   logic [7:0] ph_a;
   logic [7:0] acc_c;
   logic [1:0] req_c;
   logic [1:0] desc_lvl;
   logic [1:0] cur_lvl;
   // cmd is true at the edge that ends a command data phase
   assign cmd = ph_w && ph_a == SPC_OFS_CMD;
   assign desc_lvl = acc_c[6:5];
   assign cur_lvl = current_priv_level;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_w <= 1'b0;
         ph_a <= 8'h00;
         acc_c <= 8'h00;
         req_c <= 2'h0;
      end else if (hready) begin
         ph_w <= hsel && htrans[1] && hwrite;
         ph_a <= haddr[7:0];
         if (ph_w && ph_a == SPC_OFS_ACC) acc_c <= hwdata[7:0];
         if (ph_w && ph_a == SPC_OFS_SEL) req_c <= hwdata[1:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_fault_pulse: assert property (gp_fault |=> !gp_fault)
      else $error("fault pulse longer than one cycle");
   a_fsel_low: assert property (fault_selector[1:0] == 2'h0)
      else $error("fault selector low bits set");
   a_cs_load: assert property (cmd && hwdata[3:0] == 4'h1 |-> ##2 gp_fault)
      else $error("code register load not refused");
   a_stamp_quiet: assert property (cmd && !hwdata[0] |-> ##2 !gp_fault)
      else $error("stamp raised a fault");
   a_short_ok: assert property (cmd && hwdata[5:0] == 6'h03 |-> ##2 !gp_fault)
      else $error("short transfer faulted");
   a_jump_level: assert property (cmd && hwdata[5:0] == 6'h13
      && desc_lvl != cur_lvl
      |-> ##2 gp_fault)
      else $error("jump across levels allowed");
   a_ss_level: assert property (cmd && hwdata[3:0] == 4'h5
      && desc_lvl != cur_lvl
      |-> ##2 gp_fault)
      else $error("stack load level mismatch allowed");
   a_ds_deny: assert property (cmd && hwdata[3:0] == 4'h9 && !acc_c[3]
      && (cur_lvl > desc_lvl || req_c > desc_lvl) |-> ##2 gp_fault)
      else $error("data load privilege not enforced");
   a_ds_grant: assert property (cmd && hwdata[3:0] == 4'h9 && !acc_c[3]
      && cur_lvl <= desc_lvl && req_c <= desc_lvl
      |-> ##2 !gp_fault)
      else $error("legal data load refused");
endmodule
bind spc_checker spc_prot_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
   .hresp, .gp_fault, .fault_selector, .current_priv_level);
`default_nettype wire

// [verification/spc_exec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_exec_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   logic rdy_s = 1'b0;
   logic [31:0] rd_s;
   // outputs only move at rising edges, so a falling-edge copy avoids races
   always @(negedge hclk) begin
      rdy_s = hready;
      rd_s = hrdata;
   end
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hwdata <= ~hwdata;
      do @(posedge hclk); while (!rdy_s);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~haddr;
      hwdata <= d;
      do @(posedge hclk); while (!rdy_s);
      q = rd_s;
   endtask
endmodule
`default_nettype wire

// [verification/spc_checker_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_checker_tb;
   import spc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, gp_fault;
   logic [31:0] haddr, hwdata, hrdata, q, r1, r2;
   logic [1:0] htrans, current_priv_level;
   logic [2:0] hsize;
   logic [15:0] fault_selector;
   logic [15:0] segv [4];
   logic [9:0] tc [11] = '{10'h004, 10'h184, 10'h145, 10'h245,
      10'h274, 10'h26D, 10'h3C4, 10'h345, 10'h284, 10'h1AD, 10'h3FD};
   int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 32'hc555fdef;
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   spc_checker DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
      .gp_fault, .fault_selector, .current_priv_level);
   spc_exec_model u_exec (.hclk, .hready, .hrdata, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata);
   task automatic finish_test;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_exec.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      u_exec.xfer(1'b0, a, 32'h0, q);
   endtask
   function automatic logic load_ok(input logic [1:0] seg, cur, req,
      input logic [7:0] a);
      logic [1:0] d, m;
      d = a[6:5];
      m = cur > req ? cur : req;
      if (seg == 2'h0) return 1'b0;
      if (seg == 2'h1) return !a[3] && a[1] && d == cur && req == cur;
      if (a[3]) return a[1] && (a[2] || m <= d);
      return m <= d;
   endfunction
   task automatic do_load(input logic [1:0] seg, input logic [15:0] cs,
      sel, input logic [7:0] acc);
      logic ok;
      ok = load_ok(seg, cs[1:0], sel[1:0], acc);
      wr(SPC_OFS_CS, {16'h0, cs});
      segv[0] = cs;
      wr(SPC_OFS_SEL, {16'h0, sel});
      wr(SPC_OFS_ACC, {24'h0, acc});
      wr(SPC_OFS_STAT, 32'h1);
      wr(SPC_OFS_CMD, {28'h0, seg, 2'h1});
      rd(SPC_OFS_STAT);
      chk(q, {28'h0, cs[1:0], ok, !ok});
      chk(current_priv_level, cs[1:0]);
      if (ok) segv[seg] = sel;
      rd(8'h18 + {seg, 2'h0});
      chk(q, {16'h0, segv[seg]});
      if (!ok) begin
         rd(SPC_OFS_RESULT);
         chk(q, {16'h0, sel & 16'hFFFC});
         chk(fault_selector, {16'h0, sel & 16'hFFFC});
      end
   endtask
   task automatic do_stamp(input logic [15:0] sel, opnd);
      wr(SPC_OFS_SEL, {16'h0, sel});
      wr(SPC_OFS_OPND, {16'h0, opnd});
      wr(SPC_OFS_CMD, 32'h2);
      rd(SPC_OFS_RESULT);
      chk(q, {16'h0, sel[15:2], (sel[1:0] > opnd[1:0] ? sel[1:0]
         : opnd[1:0])});
   endtask
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      hresetn = 1'b0;
      segv = '{16'h0, 16'h0, 16'h0, 16'h0};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(SPC_OFS_STAT);
      chk(q, 32'h0);
      chk(hresp, 1'b0);
      wr(8'h30, 32'hFFFFFFFF);
      rd(8'h30);
      chk(q, 32'h0);
      do_load(2'h1, 16'h0002, 16'h1232, 8'h42);
      do_load(2'h1, 16'h0002, 16'h1232, 8'h62);
      do_load(2'h2, 16'h0000, 16'h4563, 8'h40);
      do_load(2'h3, 16'h0003, 16'h7770, 8'h0E);
      // requested level zero below current level one; the current level decides
      do_load(2'h2, 16'h0001, 16'h2220, 8'h22);
      do_stamp(16'hABC3, 16'h0000);
      do_stamp(16'h1230, 16'hFFF2);
      for (int i = 0; i < 40; i++) begin
         r1 = $random(seed);
         r2 = $random(seed);
         do_load(r1[1:0], r1[17:2], r2[15:0], r2[23:16]);
      end
      for (int i = 0; i < 8; i++) begin
         r1 = $random(seed);
         do_stamp(r1[15:0], r1[31:16]);
      end
      // granted far transfers move the level, so restart each case at 2
      for (int i = 0; i < 11; i++) begin
         // sticky fault from the case before must not leak into this one
         wr(SPC_OFS_STAT, 32'h1);
         wr(SPC_OFS_CS, 32'h2);
         wr(SPC_OFS_SEL, {16'h0, 14'h0280, tc[i][2:1]});
         wr(SPC_OFS_ACC, {25'h0, tc[i][7:6], 5'h0A});
         wr(SPC_OFS_CMD, {23'h0, tc[i][4:3], tc[i][5], tc[i][9:8], 4'h3});
         rd(SPC_OFS_STAT);
         chk(q[0], tc[i][0]);
         chk(current_priv_level, (tc[i][0] || tc[i][9:8] == 2'h0)
            ? 2'h2 : tc[i][7:6]);
      end
      finish_test;
   end
endmodule
`default_nettype wire
